// ---- rtl/adcseq_regs.svh ----
// register offsets, field positions and timing counts
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH
`define ADCSEQ_OFF_CTRL      8'h00
`define ADCSEQ_OFF_CFG       8'h04
`define ADCSEQ_OFF_RESULT    8'h08
`define ADCSEQ_OFF_PRIOR     8'h0c
`define ADCSEQ_OFF_SUM       8'h10
`define ADCSEQ_OFF_DEV       8'h14
`define ADCSEQ_OFF_LTH       8'h18
`define ADCSEQ_OFF_UTH       8'h1c
`define ADCSEQ_OFF_STAT      8'h20
`define ADCSEQ_OFF_MASK      8'h24
`define ADCSEQ_OFF_CAP       8'h28
`define ADCSEQ_OFF_SETPT     8'h2c
`define ADCSEQ_CTRL_ON       0
`define ADCSEQ_CTRL_GO       1
`define ADCSEQ_CTRL_REPEAT_CONVERSION_BIT     2
`define ADCSEQ_CFG_PSIS      0
`define ADCSEQ_CFG_DSEN      1
`define ADCSEQ_CFG_RCOSC     2
`define ADCSEQ_CFG_TMD_LO    3
`define ADCSEQ_CFG_TRG_LO    6
`define ADCSEQ_ST_CONV       0
`define ADCSEQ_ST_THR        1
`define ADCSEQ_ST_COMPUTATION_DONE_FLAG       2
`define ADCSEQ_ST_BELOW      3
`define ADCSEQ_ST_ABOVE      4
`define ADCSEQ_CAP_W         5
`define ADCSEQ_INSTR_NS      80
`define ADCSEQ_CLK_NS        20
`define ADCSEQ_INSTR_CYC     ((`ADCSEQ_INSTR_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS)
`endif

// ---- rtl/adcseq_pkg.sv ----
// types of the conversion sequencer
package adcseq_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_CONV  = 5'b00100,
        ST_COMPUTATION_DONE_FLAG  = 5'b01000,
        ST_OFF   = 5'b10000
    } adcseq_state_t;
    // first field is the top bit: b7:6 trigger, b5:3 mode, b2 osc, b1 double, b0 prior
    typedef struct packed {
        logic [1:0] trg_sel;
        logic [2:0] tmd;
        logic       rcosc;
        logic       dsen;
        logic       psis;
    } adcseq_cfg_t;
endpackage

// ---- rtl/adcseq_top.sv ----
// conversion sequencer with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_regs.svh"
// Overview of operation
// - nothing converts until software sets the enable bit.
// - conversions start by go bit, selected trigger or continuous retrigger.
// - with prior select set, old result is copied before new result lands.
// - go clears at completion unless repeat bit is set.
// - each completion sets conversion flag, computation_done_flag flag and adds to sum.
// - deviation recomputed every conversion, or every second with double sample.
// - recomputed deviation meeting threshold mode sets threshold flag.
// - filter and threshold results follow the conversion flag by a cycle.
// - conversion in sleep proceeds only with dedicated oscillator clock.
// - dedicated oscillator adds one instruction cycle before conversion.
// - completion in sleep with interrupt enabled raises wake.
// - completion in sleep with interrupt disabled powers down, enable stays.
// - trigger in sleep with dedicated oscillator runs full conversion.
// - trigger in sleep on other clocks is held pending until wake.
// - five-bit extra capacitor field, code equals picofarads, upper bits zero.
// - thresholds compared to deviation set below and above flags.
module adcseq_top
    import adcseq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  ext_trigger,
    input  wire logic        sleep_mode,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    output logic             analog_power,
    output logic [4:0]       extra_sample_cap,
    output logic             wake_request,
    output logic             irq
);
    localparam int DLY_CYC = `ADCSEQ_INSTR_CYC;

    logic [2:0]    converter_control_reg_ff;
    adcseq_cfg_t   cfg_ff;
    logic [15:0]   conversion_result_ff;
    logic [15:0]   prior_result_ff;
    logic [31:0]   running_sum_ff;
    logic [15:0]   deviation_ff;
    logic [15:0]   lower_threshold_ff;
    logic [15:0]   upper_threshold_ff;
    logic [15:0]   setpoint_ff;
    logic [4:0]    status_ff;
    logic [4:0]    mask_ff;
    logic [4:0]    cap_ff;
    adcseq_state_t state_ff;
    logic [3:0]    dly_ff;
    logic          trig_prev_ff;
    logic          pend_ff;
    logic          odd_ff;
    logic          wake_ff;
    logic          start_ff;
    logic          aw_ff;
    logic          w_ff;
    logic [7:0]    awaddr_ff;
    logic [31:0]   wdata_ff;
    logic          wstrb0_ff;
    logic          bvalid_ff;
    logic          rvalid_ff;
    logic [31:0]   rdata_ff;

    // axi4-lite write channel: address and data latched independently
    logic wr_fire;
    assign s_axi_awready = ~aw_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_ff & ~bvalid_ff;
    assign wr_fire       = aw_ff & w_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff      <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_ff     <= 1'b0;
                w_ff      <= 1'b0;
                bvalid_ff <= 1'b1;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    logic wr_ctrl, wr_stat;
    logic [7:0] wb0;
    assign wr_ctrl = wr_fire && awaddr_ff == `ADCSEQ_OFF_CTRL;
    assign wr_stat = wr_fire && awaddr_ff == `ADCSEQ_OFF_STAT;
    assign wb0     = wdata_ff[7:0];

    // trigger select and rising edge detection
    logic trig_sel, trig_rise;
    assign trig_sel  = ext_trigger[cfg_ff.trg_sel];
    assign trig_rise = trig_sel & ~trig_prev_ff;

    logic on, go, repeat_conversion_bit, idle, start_req, can_run;
    assign on   = converter_control_reg_ff[`ADCSEQ_CTRL_ON];
    assign go   = converter_control_reg_ff[`ADCSEQ_CTRL_GO];
    assign repeat_conversion_bit = converter_control_reg_ff[`ADCSEQ_CTRL_REPEAT_CONVERSION_BIT];
    assign idle = state_ff == ST_IDLE;
    assign can_run = ~sleep_mode | cfg_ff.rcosc;
    assign start_req = on & idle & can_run & (go | pend_ff);

    // threshold evaluation on the new deviation
    logic [15:0] dev_new;
    logic        below, above, thr_hit, do_err;
    assign dev_new = conv_data - setpoint_ff;
    assign below   = $signed(dev_new) < $signed(lower_threshold_ff);
    assign above   = $signed(dev_new) > $signed(upper_threshold_ff);
    assign do_err  = ~cfg_ff.dsen | odd_ff;
    always_comb begin
        unique case (cfg_ff.tmd)
            3'h1:    thr_hit = below;
            3'h2:    thr_hit = ~below & ~above;
            3'h3:    thr_hit = below | above;
            3'h4:    thr_hit = above;
            3'h7:    thr_hit = 1'b1;
            default: thr_hit = 1'b0;
        endcase
    end

    logic done_ev;
    assign done_ev = state_ff == ST_CONV && conv_done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            dly_ff   <= 4'h0;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_req) begin
                        if (cfg_ff.rcosc) begin
                            state_ff <= ST_DELAY;
                            dly_ff   <= 4'(DLY_CYC - 1);
                        end else begin
                            state_ff <= ST_CONV;
                            start_ff <= 1'b1;
                        end
                    end
                end
                ST_DELAY: begin
                    if (dly_ff == 4'h0) begin
                        state_ff <= ST_CONV;
                        start_ff <= 1'b1;
                    end else begin
                        dly_ff <= dly_ff - 4'h1;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        state_ff <= ST_COMPUTATION_DONE_FLAG;
                    end
                end
                ST_COMPUTATION_DONE_FLAG: begin
                    if (sleep_mode && !mask_ff[`ADCSEQ_ST_CONV]) begin
                        state_ff <= ST_OFF;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_OFF: begin
                    if (!sleep_mode || !on) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign conv_start   = start_ff;
    assign analog_power = on & (state_ff != ST_OFF);

    // control register: go self-clears unless continuous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_reg_ff <= 3'h0;
        end else if (wr_ctrl && wstrb0_ff) begin
            converter_control_reg_ff <= wb0[2:0];
        end else if (done_ev && !repeat_conversion_bit) begin
            converter_control_reg_ff[`ADCSEQ_CTRL_GO] <= 1'b0;
        end
    end

    // pending trigger; also continuous retrigger via go held set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev_ff <= 1'b0;
            pend_ff      <= 1'b0;
        end else begin
            trig_prev_ff <= trig_sel;
            if (trig_rise && on) begin
                pend_ff <= 1'b1;
            end else if (start_req) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // result, prior, sum
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_result_ff <= 16'h0000;
            prior_result_ff      <= 16'h0000;
            running_sum_ff       <= 32'h0000_0000;
        end else if (done_ev) begin
            if (cfg_ff.psis) begin
                prior_result_ff <= conversion_result_ff;
            end
            conversion_result_ff <= conv_data;
            running_sum_ff <= running_sum_ff + {16'h0000, conv_data};
        end else if (wr_fire && awaddr_ff == `ADCSEQ_OFF_SUM) begin
            running_sum_ff <= wdata_ff;
        end
    end

    // deviation registered a cycle after the result; pairing counter registered with the result
    logic        computation_done_flag_ev, thr_ev;
    logic [15:0] dev_hold_ff;
    logic        thr_hold_ff, be_ff, ab_ff, err_hold_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            odd_ff       <= 1'b0;
            deviation_ff <= 16'h0000;
            dev_hold_ff  <= 16'h0000;
            thr_hold_ff  <= 1'b0;
            be_ff        <= 1'b0;
            ab_ff        <= 1'b0;
            err_hold_ff  <= 1'b0;
        end else begin
            if (done_ev) begin
                odd_ff      <= cfg_ff.dsen ? ~odd_ff : 1'b0;
                dev_hold_ff <= dev_new;
                thr_hold_ff <= thr_hit;
                be_ff       <= below;
                ab_ff       <= above;
                err_hold_ff <= do_err;
            end
            if (state_ff == ST_COMPUTATION_DONE_FLAG && err_hold_ff) begin
                deviation_ff <= dev_hold_ff;
            end
        end
    end
    assign computation_done_flag_ev = state_ff == ST_COMPUTATION_DONE_FLAG;
    assign thr_ev  = computation_done_flag_ev & err_hold_ff & thr_hold_ff;

    // sticky status, set wins over write-one-clear
    logic [4:0] set_v;
    assign set_v = {computation_done_flag_ev & err_hold_ff & ab_ff, computation_done_flag_ev & err_hold_ff & be_ff,
                    done_ev, thr_ev, done_ev};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= 5'h00;
        end else begin
            status_ff <= (status_ff & ~((wr_stat && wstrb0_ff) ? wb0[4:0] : 5'h00))
                         | set_v;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= sleep_mode & computation_done_flag_ev & mask_ff[`ADCSEQ_ST_CONV];
        end
    end
    assign wake_request = wake_ff;
    assign irq = |(status_ff & mask_ff);

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff             <= '0;
            lower_threshold_ff <= 16'h0000;
            upper_threshold_ff <= 16'h0000;
            setpoint_ff        <= 16'h0000;
            mask_ff            <= 5'h00;
            cap_ff             <= 5'h00;
        end else if (wr_fire && wstrb0_ff) begin
            unique case (awaddr_ff)
                `ADCSEQ_OFF_CFG:   cfg_ff <= wb0;
                `ADCSEQ_OFF_LTH:   lower_threshold_ff <= wdata_ff[15:0];
                `ADCSEQ_OFF_UTH:   upper_threshold_ff <= wdata_ff[15:0];
                `ADCSEQ_OFF_SETPT: setpoint_ff <= wdata_ff[15:0];
                `ADCSEQ_OFF_MASK:  mask_ff <= wb0[4:0];
                `ADCSEQ_OFF_CAP:   cap_ff <= wb0[4:0];
                default: ;
            endcase
        end
    end
    assign extra_sample_cap = cap_ff;

    // read channel
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            `ADCSEQ_OFF_CTRL:   rd_mux = {29'h0, converter_control_reg_ff};
            `ADCSEQ_OFF_CFG:    rd_mux = {24'h0, cfg_ff};
            `ADCSEQ_OFF_RESULT: rd_mux = {16'h0, conversion_result_ff};
            `ADCSEQ_OFF_PRIOR:  rd_mux = {16'h0, prior_result_ff};
            `ADCSEQ_OFF_SUM:    rd_mux = running_sum_ff;
            `ADCSEQ_OFF_DEV:    rd_mux = {16'h0, deviation_ff};
            `ADCSEQ_OFF_LTH:    rd_mux = {16'h0, lower_threshold_ff};
            `ADCSEQ_OFF_UTH:    rd_mux = {16'h0, upper_threshold_ff};
            `ADCSEQ_OFF_STAT:   rd_mux = {27'h0, status_ff};
            `ADCSEQ_OFF_MASK:   rd_mux = {27'h0, mask_ff};
            `ADCSEQ_OFF_CAP:    rd_mux = {27'h0, cap_ff};
            `ADCSEQ_OFF_SETPT:  rd_mux = {16'h0, setpoint_ff};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    a_no_start_off: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start |-> $past(on)) else $error("start while disabled");
    a_go_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ev && !repeat_conversion_bit && !wr_ctrl |=> !go) else $error("go not cleared");
    a_go_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ev && repeat_conversion_bit && go && !wr_ctrl |=> go) else $error("go lost in repeat_conversion_bit");
    a_conv_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ev |=> status_ff[`ADCSEQ_ST_CONV] && status_ff[`ADCSEQ_ST_COMPUTATION_DONE_FLAG])
        else $error("completion flags missing");
    a_sum_add: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ev |=> running_sum_ff == $past(running_sum_ff) + {16'h0000, $past(conv_data)})
        else $error("sum not updated");
    a_prior_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        done_ev && cfg_ff.psis |=> prior_result_ff == $past(conversion_result_ff))
        else $error("prior not copied");
    a_rc_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        idle && start_req && cfg_ff.rcosc |-> ##1 !conv_start [*4] ##1 conv_start)
        else $error("oscillator delay wrong");
    a_sleep_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start |-> $past(can_run, 1) || $past(state_ff == ST_DELAY))
        else $error("conversion in sleep");
    a_thr_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        thr_ev |=> status_ff[`ADCSEQ_ST_THR]) else $error("threshold flag missing");
endmodule
`default_nettype wire

// ---- tb/adcseq_analog_model.sv ----
// analog core model: answers each conversion start with a result
`timescale 1ns/1ps
`default_nettype none
module adcseq_analog_model #(
    parameter int CONV_CYC = 6
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        conv_start,
    input  wire logic [15:0] sample_value,
    output logic             conv_done = 1'b0,
    output logic [15:0]      conv_data = 16'h0
);
    int          cnt = 0;
    logic [15:0] last = 16'h0;
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        // data only meaningful with the done pulse
        conv_data <= ~last;
        if (!aresetn) begin
            cnt <= 0;
        end else if (conv_start) begin
            cnt <= CONV_CYC;
        end else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= sample_value;
            last <= sample_value;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/adcseq_top_tb.sv ----
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_regs.svh"
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module adcseq_top_tb
    import adcseq_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, w, acc, prev, last;
    logic [3:0]  s_axi_wstrb = 4'hf, ext_trigger = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_mode = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        conv_start, conv_done, analog_power, wake_request, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] conv_data, sample_value = 16'h0, v;
    logic [4:0]  extra_sample_cap;
    logic [2:0]  modes [8] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd7, 3'd5, 3'd6};
    int          error_cnt = 0, checks = 0, starts = 0, dones = 0, wakes = 0, cyc = 0;
    int          n, l0, l1, thr_sum;

    adcseq_top adcseq_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger, .sleep_mode, .conv_start,
        .conv_done, .conv_data, .analog_power, .extra_sample_cap, .wake_request, .irq);
    adcseq_analog_model adcseq_analog_model_i (.aclk, .aresetn, .conv_start, .sample_value,
        .conv_done, .conv_data);

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (conv_start === 1'b1) starts++;
        if (conv_done === 1'b1) dones++;
        if (wake_request === 1'b1) wakes++;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        error_cnt++;
        $display("CHECK FAILED %s exp answer got none", what);
        give_verdict();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                `CHK("bresp", 2'h0, s_axi_bresp);
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("bvalid");
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
                d = s_axi_rdata;
                `CHK("rresp", 2'h0, s_axi_rresp);
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("rvalid");
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] ex, input string nm);
        axr(a, rd);
        `CHK(nm, ex, rd);
    endtask

    task automatic wait_for(input int which, input int target);
        for (int i = 0; i < 400; i++) begin
            @(negedge aclk);
            if ((which == 0 ? starts : which == 1 ? dones : wakes) >= target) return;
        end
        hang("event");
    endtask

    task automatic do_conv(input logic [15:0] s);
        n = dones;
        @(posedge aclk);
        sample_value <= s;
        axw(`ADCSEQ_OFF_CTRL, 32'h3);
        wait_for(1, n + 1);
        repeat (3) @(posedge aclk);
    endtask

    task automatic pulse_trig();
        @(posedge aclk);
        ext_trigger[1] <= 1'b1;
        repeat (3) @(posedge aclk);
        ext_trigger[1] <= 1'b0;
    endtask

    // latency from trigger edge to start; trigger held high 30 cycles afterwards, then released
    task automatic trig(output int lat);
        int s;
        int t;
        s = starts;
        @(negedge aclk);
        t = cyc;
        @(posedge aclk);
        ext_trigger[1] <= 1'b1;
        wait_for(0, s + 1);
        lat = cyc - t;
        repeat (30) @(posedge aclk);
        `CHK("one start per edge", s + 1, starts);
        ext_trigger[1] <= 1'b0;
    endtask

    // status word {above, below, computation_done_flag, thr, conv}; setpoint 0x800, window -256..256
    function automatic logic [4:0] exp_stat(input logic [15:0] s, input logic [2:0] m);
        int   d;
        logic b;
        logic a;
        logic t;
        d = int'(s) - 2048;
        b = d < -256;
        a = d > 256;
        case (m)
            3'd1: t = b;
            3'd2: t = !b && !a;
            3'd3: t = b || a;
            3'd4: t = a;
            3'd7: t = 1'b1;
            default: t = 1'b0;
        endcase
        return {a, b, 1'b1, t, 1'b1};
    endfunction

    initial begin
        void'($urandom(32'h1d73));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk_reg(`ADCSEQ_OFF_CTRL, 32'h0, "ctrl reset");
        chk_reg(`ADCSEQ_OFF_STAT, 32'h0, "stat reset");
        chk_reg(8'h30, 32'h0, "unmapped");
        $display("test reset done");
        axw(`ADCSEQ_OFF_CTRL, 32'h2);
        repeat (20) @(posedge aclk);
        `CHK("start while off", 0, starts);
        `CHK("power while off", 1'b0, analog_power);
        axw(`ADCSEQ_OFF_CTRL, 32'h1);
        `CHK("power on", 1'b1, analog_power);
        $display("test enable done");
        axw(`ADCSEQ_OFF_SETPT, 32'h800);
        axw(`ADCSEQ_OFF_LTH, 32'hff00);
        axw(`ADCSEQ_OFF_UTH, 32'h100);
        axw(`ADCSEQ_OFF_MASK, 32'h1);
        acc = 0;
        prev = 0;
        last = 0;
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom_range(0, 16'hfff));
            axw(`ADCSEQ_OFF_CFG, 32'({modes[i], 2'b00, 1'(i)}));
            do_conv(v);
            acc = acc + 32'(v);
            if (i[0]) prev = last;
            last = 32'(v);
            chk_reg(`ADCSEQ_OFF_RESULT, 32'(v), "result");
            chk_reg(`ADCSEQ_OFF_PRIOR, prev, "prior");
            chk_reg(`ADCSEQ_OFF_CTRL, 32'h1, "go cleared");
            chk_reg(`ADCSEQ_OFF_SUM, acc, "sum");
            chk_reg(`ADCSEQ_OFF_STAT, 32'(exp_stat(v, modes[i])), "status");
            axr(`ADCSEQ_OFF_DEV, rd);
            `CHK("deviation", 16'(v - 16'h800), rd[15:0]);
            `CHK("irq set", 1'b1, irq);
            axw(`ADCSEQ_OFF_STAT, 32'h1f);
            `CHK("irq cleared", 1'b0, irq);
        end
        $display("test conversions done");
        axw(`ADCSEQ_OFF_CFG, 32'h3a);
        thr_sum = 0;
        repeat (2) begin
            do_conv(16'($urandom_range(0, 16'hfff)));
            axr(`ADCSEQ_OFF_STAT, rd);
            thr_sum += int'(rd[1]);
            axw(`ADCSEQ_OFF_STAT, 32'h1f);
        end
        `CHK("threshold every other", 1, thr_sum);
        $display("test double sample done");
        axw(`ADCSEQ_OFF_CFG, 32'h0);
        n = starts;
        axw(`ADCSEQ_OFF_CTRL, 32'h7);
        wait_for(0, n + 3);
        chk_reg(`ADCSEQ_OFF_CTRL, 32'h7, "go held");
        axw(`ADCSEQ_OFF_CTRL, 32'h1);
        repeat (30) @(posedge aclk);
        $display("test continuous done");
        for (int i = 0; i < 3; i++) begin
            w = (i == 0) ? 32'hff : $urandom;
            axw(`ADCSEQ_OFF_CAP, w);
            chk_reg(`ADCSEQ_OFF_CAP, w & 32'h1f, "cap");
            `CHK("cap pins", w[4:0], extra_sample_cap);
        end
        $display("test capacitor done");
        axw(`ADCSEQ_OFF_CFG, 32'h40);
        trig(l0);
        axw(`ADCSEQ_OFF_CFG, 32'h44);
        trig(l1);
        `CHK("osc delay", `ADCSEQ_INSTR_CYC, l1 - l0);
        $display("test trigger done");
        axw(`ADCSEQ_OFF_CFG, 32'h40);
        n = starts;
        sleep_mode <= 1'b1;
        pulse_trig();
        repeat (30) @(posedge aclk);
        `CHK("no start asleep", n, starts);
        sleep_mode <= 1'b0;
        wait_for(0, n + 1);
        repeat (30) @(posedge aclk);
        axw(`ADCSEQ_OFF_CFG, 32'h44);
        axw(`ADCSEQ_OFF_STAT, 32'h1f);
        n = wakes;
        sleep_mode <= 1'b1;
        pulse_trig();
        wait_for(2, n + 1);
        axr(`ADCSEQ_OFF_STAT, rd);
        `CHK("flag asleep", 1'b1, rd[0]);
        sleep_mode <= 1'b0;
        axw(`ADCSEQ_OFF_STAT, 32'h1f);
        axw(`ADCSEQ_OFF_MASK, 32'h0);
        n = wakes;
        l0 = dones;
        sleep_mode <= 1'b1;
        pulse_trig();
        wait_for(1, l0 + 1);
        repeat (3) @(posedge aclk);
        `CHK("powered down", 1'b0, analog_power);
        axr(`ADCSEQ_OFF_CTRL, rd);
        `CHK("enable kept", 1'b1, rd[0]);
        `CHK("irq masked", 1'b0, irq);
        `CHK("no wake", n, wakes);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK("power back", 1'b1, analog_power);
        $display("test sleep done");
        give_verdict();
    end
endmodule
`default_nettype wire
